// ### hdl/trap_irq_pkg.sv
package trap_irq_pkg;
    // trap opcode and vector low bytes
    localparam logic [7:0] trap_opcode      = 8'h00;
    localparam logic [7:0] vec_trap         = 8'hFE;
    localparam logic [7:0] vec_port_edge    = 8'hE2;
    localparam logic [7:0] vec_default      = 8'hE0;
    // stack limit addresses for the two ram sizes
    localparam logic [7:0] stack_limit_small = 8'h2F;
    localparam logic [7:0] stack_limit_large = 8'h6F;
    // register offsets (word addresses on the avalon bus)
    localparam logic [3:0] off_wake_enable  = 4'h0;
    localparam logic [3:0] off_wake_edge    = 4'h1;
    localparam logic [3:0] off_wake_pending = 4'h2;
    localparam logic [3:0] off_control      = 4'h3;
    localparam logic [3:0] off_status       = 4'h4;
    // control register field positions
    localparam int ctl_master_en_bit = 0;
    localparam int ctl_gie_bit       = 1;
    localparam int ctl_large_ram_bit = 2;
    // reset values
    localparam logic [7:0] wake_enable_rst  = 8'h00;
    localparam logic [7:0] wake_edge_rst    = 8'h00;
    localparam logic [7:0] wake_pending_rst = 8'h00;
    localparam logic [2:0] control_rst      = 3'h0;
    localparam int port_width = 8;

    // core event strobes from the instruction sequencer
    typedef struct packed {
        logic       ir_load;       // instruction register loaded this cycle
        logic [7:0] ir_byte;       // byte loaded
        logic [14:0] fetch_addr;   // address of that fetch
        logic       fetch_oob;     // fetch address beyond implemented space
        logic       pop;           // stack pop this cycle
        logic [7:0] sp_after_pop;  // stack pointer after the pop
        logic       clr_trap;      // clear-trap-pending instruction executed
        logic       vis_exec;      // vector select instruction first cycle
        logic       irq_ack;       // core entered a maskable routine
        logic       return_from_irq_instr;          // return from irq executed
        logic       asleep;        // halt or idle mode active
    } core_evt_t;
endpackage

// ### hdl/trap_and_edge_irq_logic.sv
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module trap_and_edge_irq_logic (
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    input  wire trap_irq_pkg::core_evt_t core_evt,
    input  wire logic [7:0]              port_pins,
    input  wire logic [7:0]              pmem_rdata,
    input  wire logic [3:0]              avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    output logic [31:0]                  avs_readdata,
    output logic                         avs_waitrequest,
    output logic [7:0]                   ir_data,
    output logic                         trap_take,
    output logic [14:0]                  trap_ret_addr,
    output logic                         irq_req,
    output logic [7:0]                   vector_low,
    output logic                         vector_valid,
    output logic                         wake_req,
    output logic                         wake_via_isr
);

    logic [7:0]  wakeup_irq_enable_reg;     // per-pin enables
    logic [7:0]  wakeup_edge_select_reg;    // 1 = falling edge, 0 = rising
    logic [7:0]  wakeup_pending_reg;        // sticky edge latches
    logic [7:0]  wakeup_pending_next;       // pending next value
    logic [2:0]  control_reg;               // master enable, gie, ram size
    logic        trap_pending_flag;         // hidden trap flag
    logic        in_maskable_reg;           // maskable routine running
    logic [7:0]  pins_prev_reg;             // previous pin sample
    logic [7:0]  edge_hit;                  // selected transitions this cycle
    logic        trap_event;                // any trap cause this cycle
    logic [7:0]  ir_byte_eff;               // fetched byte after range fix
    logic [7:0]  stack_limit;               // active stack limit
    logic        port_active;               // port group request raw
    logic        ack_pulse_reg;             // single-cycle bus acknowledge
    logic        bus_req;                   // bus access in flight
    logic        wr_strobe;                 // write takes effect
    logic        port_master_en;            // port_group_irq_master_enable
    logic        global_interrupt_enable;   // gie bit

    assign port_master_en          = control_reg[trap_irq_pkg::ctl_master_en_bit];
    assign global_interrupt_enable = control_reg[trap_irq_pkg::ctl_gie_bit];
    assign bus_req   = avs_read | avs_write;
    assign wr_strobe = avs_write & ack_pulse_reg;

    // out-of-range fetches read as zero and decode as trap opcode
    assign ir_byte_eff = core_evt.fetch_oob ? 8'h00 : core_evt.ir_byte;
    assign stack_limit = control_reg[trap_irq_pkg::ctl_large_ram_bit]
                       ? trap_irq_pkg::stack_limit_large
                       : trap_irq_pkg::stack_limit_small;

    // trap causes: opcode fetch or stack overpop
    assign trap_event = (core_evt.ir_load && ir_byte_eff == trap_irq_pkg::trap_opcode)
                      || (core_evt.pop && core_evt.sp_after_pop > stack_limit);

    // transition detect on the registered sample
    assign edge_hit = (port_pins & ~pins_prev_reg & ~wakeup_edge_select_reg)
                    | (~port_pins & pins_prev_reg & wakeup_edge_select_reg);

    assign port_active = |(wakeup_pending_reg & wakeup_irq_enable_reg);

    // pin sampler
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pins_prev_reg <= 8'h00;
        end else begin
            pins_prev_reg <= port_pins;
        end
    end

    // hidden trap pending flag; set beats clear; never on the bus
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            trap_pending_flag <= 1'b0;
        end else if (trap_event) begin
            trap_pending_flag <= 1'b1;
        end else if (core_evt.clr_trap) begin
            trap_pending_flag <= 1'b0;
        end
    end

    // trap take strobe and return address of the trap instruction
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            trap_take     <= 1'b0;
            trap_ret_addr <= 15'h0000;
            ir_data       <= 8'h00;
        end else begin
            trap_take <= trap_event;
            if (core_evt.ir_load) begin
                ir_data <= ir_byte_eff;
            end
            if (trap_event) begin
                trap_ret_addr <= core_evt.fetch_addr;
            end
        end
    end

    // tracks a running maskable routine so it is not preempted
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            in_maskable_reg <= 1'b0;
        end else if (core_evt.irq_ack) begin
            in_maskable_reg <= 1'b1;
        end else if (core_evt.return_from_irq_instr) begin
            in_maskable_reg <= 1'b0;
        end
    end

    // maskable request: gated by master, gie, trap lockout and nesting
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_req <= 1'b0;
        end else begin
            irq_req <= port_active && port_master_en && global_interrupt_enable
                    && !trap_pending_flag && !trap_event
                    && !in_maskable_reg;
        end
    end

    // vector arbitration on the vector select instruction
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            vector_low   <= trap_irq_pkg::vec_default;
            vector_valid <= 1'b0;
        end else begin
            vector_valid <= core_evt.vis_exec;
            if (core_evt.vis_exec) begin
                if (trap_pending_flag) begin
                    vector_low <= trap_irq_pkg::vec_trap;
                end else if (port_active && port_master_en) begin
                    vector_low <= trap_irq_pkg::vec_port_edge;
                end else begin
                    vector_low <= trap_irq_pkg::vec_default;
                end
            end
        end
    end

    // wakeup from halt or idle; isr path only if interrupt enabled
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wake_req     <= 1'b0;
            wake_via_isr <= 1'b0;
        end else begin
            wake_req     <= core_evt.asleep && port_active;
            wake_via_isr <= core_evt.asleep && port_active
                         && port_master_en && global_interrupt_enable;
        end
    end

    // pending next: new edges set, write-one clears, set wins
    always_comb begin
        wakeup_pending_next = wakeup_pending_reg;
        if (wr_strobe && avs_address == trap_irq_pkg::off_wake_pending) begin
            wakeup_pending_next = wakeup_pending_next & ~avs_writedata[7:0];
        end
        wakeup_pending_next = wakeup_pending_next | edge_hit;
    end

    // pending register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wakeup_pending_reg <= trap_irq_pkg::wake_pending_rst;
        end else begin
            wakeup_pending_reg <= wakeup_pending_next;
        end
    end

    // software registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wakeup_irq_enable_reg  <= trap_irq_pkg::wake_enable_rst;
            wakeup_edge_select_reg <= trap_irq_pkg::wake_edge_rst;
            control_reg            <= trap_irq_pkg::control_rst;
        end else if (wr_strobe) begin
            unique case (avs_address)
                trap_irq_pkg::off_wake_enable: begin
                    wakeup_irq_enable_reg <= avs_writedata[7:0];
                end
                trap_irq_pkg::off_wake_edge: begin
                    wakeup_edge_select_reg <= avs_writedata[7:0];
                end
                trap_irq_pkg::off_control: begin
                    control_reg <= avs_writedata[2:0];
                end
                default: begin
                    // pending is write-one-clear in the pending next logic; status and unmapped offsets ignore writes
                end
            endcase
        end
    end

    // bus handshake: one wait cycle, then acknowledge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack_pulse_reg <= 1'b0;
        end else begin
            ack_pulse_reg <= bus_req && !ack_pulse_reg;
        end
    end

    // waitrequest high unless acknowledging
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !(bus_req && !ack_pulse_reg);
        end
    end

    // read data, valid in the acknowledge cycle; unmapped reads zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !ack_pulse_reg) begin
            unique case (avs_address)
                trap_irq_pkg::off_wake_enable:
                    avs_readdata <= {24'h000000, wakeup_irq_enable_reg};
                trap_irq_pkg::off_wake_edge:
                    avs_readdata <= {24'h000000, wakeup_edge_select_reg};
                trap_irq_pkg::off_wake_pending:
                    avs_readdata <= {24'h000000, wakeup_pending_reg};
                trap_irq_pkg::off_control:
                    avs_readdata <= {29'h00000000, control_reg};
                trap_irq_pkg::off_status:
                    avs_readdata <= {30'h00000000, in_maskable_reg, port_active};
                default:
                    avs_readdata <= 32'h00000000;
            endcase
        end
    end

endmodule

// ### verif/trap_irq_checker.sv
`timescale 1ns/1ps
module trap_irq_checker (
    input wire logic                    ref_clk,
    input wire logic                    rst,
    input wire trap_irq_pkg::core_evt_t core_evt,
    input wire logic [7:0]              ir_data,
    input wire logic                    trap_take,
    input wire logic [14:0]             trap_ret_addr,
    input wire logic                    irq_req,
    input wire logic [7:0]              vector_low,
    input wire logic                    vector_valid
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // fetch-side trap cause and any possible trap cause
    logic op_trap;
    logic any_cause;
    assign op_trap = core_evt.ir_load && (core_evt.ir_byte == 8'h00 || core_evt.fetch_oob);
    assign any_cause = op_trap || (core_evt.pop && core_evt.sp_after_pop > 8'h2F);
    a_opcode_trap: assert property (core_evt.ir_load && core_evt.ir_byte == 8'h00 |=> trap_take)
        else $error("opcode 00 did not trap");
    a_oob_zero: assert property (core_evt.ir_load && core_evt.fetch_oob |=> trap_take && ir_data == 8'h00)
        else $error("out of range fetch did not trap as zero");
    a_ret_addr: assert property (op_trap |=> trap_ret_addr == $past(core_evt.fetch_addr))
        else $error("return address is not the trap fetch");
    a_overpop_trap: assert property (core_evt.pop && core_evt.sp_after_pop > 8'h6F |=> trap_take)
        else $error("overpop did not trap");
    a_take_cause: assert property (trap_take |-> $past(any_cause))
        else $error("trap taken without a cause");
    a_trap_lock: assert property (trap_take |-> !irq_req ##1 !irq_req)
        else $error("maskable request during trap");
    a_ack_block: assert property (core_evt.irq_ack ##1 !core_evt.return_from_irq_instr |=> !irq_req)
        else $error("maskable request inside a routine");
    a_vis_answer: assert property (core_evt.vis_exec |=> vector_valid)
        else $error("no vector after vector select");
    a_vec_range: assert property (vector_valid |-> !vector_low[0] && vector_low >= 8'hE0)
        else $error("vector byte odd or below E0");
    a_trap_vec: assert property (trap_take ##1 core_evt.vis_exec |=> vector_low == 8'hFE)
        else $error("trap does not win vector select");
endmodule
bind trap_and_edge_irq_logic trap_irq_checker i_chk (.ref_clk, .rst, .core_evt, .ir_data,
    .trap_take, .trap_ret_addr, .irq_req, .vector_low, .vector_valid);

// ### verif/pin_model.sv
`timescale 1ns/1ps
module pin_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] pin_target,
    output logic [7:0]      port_pins
);
    // board pins settle one clock after the level is asked for
    initial port_pins = 8'h00;
    always @(posedge ref_clk) begin
        port_pins <= pin_target;
    end
endmodule

// ### verif/trap_and_edge_irq_logic_bench.sv
`timescale 1ns/1ps
module trap_and_edge_irq_logic_bench;
    logic                    ref_clk, rst, avs_read, avs_write, avs_waitrequest;
    logic                    trap_take, irq_req, vector_valid, wake_req, wake_via_isr;
    trap_irq_pkg::core_evt_t core_evt, ev;
    logic [7:0]              pin_target, port_pins, ir_data, vector_low, p0, p1, es;
    logic [3:0]              avs_address;
    logic [31:0]             avs_writedata, avs_readdata, rd;
    logic [14:0]             trap_ret_addr;
    integer                  n_fail, check_count, seed, cyc, i;
    trap_and_edge_irq_logic i_dut (.ref_clk, .rst, .core_evt, .port_pins, .pmem_rdata(8'h00),
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .ir_data, .trap_take, .trap_ret_addr, .irq_req, .vector_low, .vector_valid,
        .wake_req, .wake_via_isr);
    pin_model i_pins (.ref_clk, .pin_target, .port_pins);
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // expected pending bits: rising unless the edge select bit asks for falling
    function logic [7:0] edge_exp(input logic [7:0] a, input logic [7:0] b, input logic [7:0] s);
        edge_exp = (~a & b & ~s) | (a & ~b & s);
    endfunction
    task check(input logic [31:0] got, input logic [31:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one-cycle core strobe by number: 0 vector select, 1 clear trap, 2 irq ack, 3 irq return
    function trap_irq_pkg::core_evt_t strobe(input int k);
        strobe          = '0;
        strobe.vis_exec = (k == 0);
        strobe.clr_trap = (k == 1);
        strobe.irq_ack  = (k == 2);
        strobe.return_from_irq_instr     = (k == 3);
    endfunction
    // one avalon transfer, held until waitrequest is sampled low at a rising edge
    task bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // one-cycle core event, outputs looked at once settled
    task pulse(input trap_irq_pkg::core_evt_t e);
        @(posedge ref_clk);
        core_evt <= e;
        @(posedge ref_clk);
        core_evt <= '0;
        @(negedge ref_clk);
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // hang guard
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            test_done;
        end
    end
    initial begin
        {n_fail, check_count, cyc} = '0;
        seed = 79;
        rst = 1'b1;
        {core_evt, pin_target, avs_address, avs_read, avs_write, avs_writedata} = '0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        check(vector_low, 8'hE0);
        for (i = 0; i < 5; i++) begin
            bus(0, i[3:0] + 4'(i / 4 * 5), 8'h00);
            if (i < 4) check(rd, 0);
        end
        check(rd, 0);
        ev = '0;
        ev.ir_load = 1'b1;
        ev.fetch_addr = 15'($random(seed));
        pulse(ev);
        check(trap_take, 1);
        check(trap_ret_addr, ev.fetch_addr);
        pulse(strobe(0));
        check(vector_low, 8'hFE);
        pulse(strobe(1));
        pulse(strobe(0));
        check(vector_low, 8'hE0);
        for (i = 0; i < 8; i++) begin
            ev.ir_byte = 8'($random(seed)) | 8'h01;
            ev.fetch_oob = (i == 7);
            pulse(ev);
            check(trap_take, i == 7);
            check(ir_data, (i == 7) ? 8'h00 : ev.ir_byte);
            pulse(strobe(1));
        end
        $display("trap causes done");
        for (i = 0; i < 4; i++) begin
            bus(1, 4'h3, {5'h0, i[1], 2'b00});
            ev = '0;
            ev.pop = 1'b1;
            ev.sp_after_pop = (i[1] ? 8'h6F : 8'h2F) + {7'h0, i[0]};
            pulse(ev);
            check(trap_take, i[0]);
            pulse(strobe(1));
        end
        $display("stack limit done");
        for (i = 0; i < 8; i++) begin
            {es, p0, p1} = 24'($random(seed));
            if (i == 0) {es, p0, p1} = {8'h0F, 8'h33, 8'hCC};
            if (i == 7) p1 = 8'hFF;
            bus(1, 4'h1, es);
            bus(1, 4'h0, 8'($random(seed)));
            pin_target <= p0;
            repeat (3) @(posedge ref_clk);
            bus(1, 4'h2, 8'hFF);
            pin_target <= p1;
            repeat (3) @(posedge ref_clk);
            bus(0, 4'h2, 8'h00);
            check(rd, {24'h0, edge_exp(p0, p1, es)});
        end
        $display("port edges done");
        bus(1, 4'h0, 8'hFF);
        bus(1, 4'h1, 8'hFF);
        pin_target <= 8'h00;
        for (i = 0; i < 4; i++) begin
            bus(1, 4'h3, {6'h0, i[1:0]});
            repeat (2) @(negedge ref_clk);
            check(irq_req, i[1] & i[0]);
        end
        pulse(strobe(0));
        check(vector_low, 8'hE2);
        pulse(strobe(2));
        @(negedge ref_clk);
        check(irq_req, 0);
        pulse(strobe(3));
        repeat (2) @(negedge ref_clk);
        check(irq_req, 1);
        ev = '0;
        ev.ir_load = 1'b1;
        pulse(ev);
        check(irq_req, 0);
        pulse(strobe(0));
        check(vector_low, 8'hFE);
        bus(0, 4'h3, 8'h00);
        check(rd, 32'h3);
        pulse(strobe(1));
        repeat (2) @(negedge ref_clk);
        check(irq_req, 1);
        $display("priority done");
        ev = '0;
        ev.asleep = 1'b1;
        pulse(ev);
        check(wake_req, 1);
        check(wake_via_isr, 1);
        bus(1, 4'h3, 8'h01);
        pulse(ev);
        check(wake_req, 1);
        check(wake_via_isr, 0);
        $display("wakeup done");
        test_done;
    end
endmodule
